//--- inc/dtp_pkg.sv
// Purpose: constants and types shared by the dual timer / PWM block
// Assumes: AHB-Lite register window, one word per register
// Notes:   offsets are byte addresses inside the slave window
`default_nettype none
package dtp_pkg;
    localparam int          DTP_AW        = 6;
    localparam int          DTP_TPS_W     = 4;
    // register byte offsets
    localparam logic [5:0]  OFS_MODE      = 6'h00;
    localparam logic [5:0]  OFS_CONB      = 6'h04;
    localparam logic [5:0]  OFS_CTRL      = 6'h08;
    localparam logic [5:0]  OFS_FLAGS     = 6'h0C;
    localparam logic [5:0]  OFS_CNT0      = 6'h10;
    localparam logic [5:0]  OFS_CNT1      = 6'h14;
    localparam logic [5:0]  OFS_RLD0      = 6'h18;
    localparam logic [5:0]  OFS_RLD1      = 6'h1C;
    localparam logic [5:0]  OFS_STAT      = 6'h20;
    // timer_mode_register fields (timer 1 fields sit 4 above timer 0)
    localparam int          MODE_M_LSB    = 0;
    localparam int          MODE_CT       = 2;
    localparam int          MODE_GATE     = 3;
    localparam int          MODE_T1_SHIFT = 4;
    // timer_control_b fields
    localparam int          CONB_PEN0     = 6;
    localparam int          CONB_PEN1     = 7;
    localparam int          CONB_PSC0_LSB = 0;
    localparam int          CONB_PSC1_LSB = 3;
    // control register fields
    localparam int          CTRL_RUN0     = 0;
    localparam int          CTRL_RUN1     = 1;
    localparam int          CTRL_COMPAT   = 2;
    localparam int          CTRL_APPLY0   = 3;
    localparam int          CTRL_APPLY1   = 4;
    localparam int          CTRL_TPS_LSB  = 8;
    // status register fields
    localparam int          STAT_OCR0_LSB = 8;
    localparam int          STAT_OCR1_LSB = 16;
    // reset values
    localparam logic [7:0]  MODE_RST      = 8'h00;
    localparam logic [7:0]  CONB_RST      = 8'h24;
    localparam logic [7:0]  CNT_RST       = 8'h00;
    localparam logic [7:0]  RLD_RST       = 8'h00;
    localparam logic [7:0]  BYTE_MAX      = 8'hFF;

    typedef enum logic [1:0] {
        DTP_M_VAR,
        DTP_M_WIDE,
        DTP_M_RELOAD,
        DTP_M_SPLIT
    } dtp_mode_e;
endpackage
`default_nettype wire

//--- rtl/dtp_timer.sv
// Purpose: timer 0 / timer 1 with 8-bit reload, split and four PWM modes
// Assumes: AHB-Lite slave, zero wait states, single word transfers
// Notes:   timer pins are two-way; oe_n low while the pin carries PWM
// Function
// - mode 2 low overflow sets flag, reloads
// - mode 2 period (256-high)*(prescale+1)
// - prescale apply bit semantics fast/compat
// - timer 1 in mode 3 holds count
// - split: low own controls, high timer1's run bit
// - split: timer 1 raises no flag
// - split overflow every 256*(prescale+1)
// - PWM enable drives wave on pin
// - flags, baud, gate still work in PWM
// - duty loads at wrap; zero holds low
// - PWM mode 0 log prescaler, set/clear
// - PWM mode 0 frequency and duty
// - PWM mode 1 linear reload prescaler
// - PWM mode 1 frequency and duty
// - PWM mode 2 toggles on overflow
// - PWM mode 2 square wave frequency
// - PWM mode 3 split channel controls
// - PWM mode 3 duties from reloads
// - mode 2 leaves reload registers free
// - log prescale bits field+1, reset 100B
// - count when run and gate allows
// - enables at bits 7,6 of control B
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dtp_timer
    import dtp_pkg::*;
#(
    parameter int TPS_W = DTP_TPS_W
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_gate_input_zero,
    input  wire logic        ext_gate_input_one,
    input  wire logic        timer_pin_a_in,
    output logic             timer_pin_a_out,
    output logic             timer_pin_a_oe_n,
    input  wire logic        timer_pin_b_in,
    output logic             timer_pin_b_out,
    output logic             timer_pin_b_oe_n,
    output logic             baud_tick
);
    generate
        if (TPS_W < 1 || TPS_W > 8) begin : g_bad_tps
            $error("TPS_W must be 1..8");
        end
    endgenerate

    logic [7:0]       mode_r;
    logic [7:0]       conb_r;
    logic [1:0]       run_r;
    logic             compat_r;
    logic [1:0]       apply_r;
    logic [TPS_W-1:0] tps_r;
    logic [TPS_W-1:0] pcnt_r;
    logic [1:0]       half_r;
    logic [1:0]       tf_r;
    logic [7:0]       low_r  [2];
    logic [7:0]       high_r [2];
    logic [7:0]       rl_r   [2];
    logic [7:0]       rh_r   [2];
    logic [7:0]       ocr_r  [2];
    logic [1:0]       pwm_r;
    logic             baud_r;
    logic [31:0]      hrdata_r;
    logic             wph_r;
    logic [DTP_AW-1:0] wadr_r;
    logic [1:0]       gs1_r, gs2_r, ps1_r, ps2_r, ps3_r;

    function automatic logic [7:0] psc_mask(input logic [2:0] psc);
        logic [8:0] m;
        m = (9'h002 << psc) - 9'h001;
        return m[7:0];
    endfunction

    function automatic logic wr_hit(input logic ph, input logic [DTP_AW-1:0] a, input logic [5:0] ofs);
        return ph && (a == ofs);
    endfunction

    // ---------------- bus slave ----------------
    logic addr_ok;
    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    function automatic logic [31:0] rd_word(input logic [DTP_AW-1:0] a, input logic [7:0] md, input logic [7:0] cb,
                                            input logic [31:0] ctl, input logic [1:0] fl, input logic [15:0] c0,
                                            input logic [15:0] c1, input logic [15:0] r0, input logic [15:0] r1,
                                            input logic [31:0] st);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            OFS_MODE:  d = {24'h000000, md};
            OFS_CONB:  d = {24'h000000, cb};
            OFS_CTRL:  d = ctl;
            OFS_FLAGS: d = {30'h0000_0000, fl};
            OFS_CNT0:  d = {16'h0000, c0};
            OFS_CNT1:  d = {16'h0000, c1};
            OFS_RLD0:  d = {16'h0000, r0};
            OFS_RLD1:  d = {16'h0000, r1};
            OFS_STAT:  d = st;
            default:   d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    logic [31:0] ctrl_word, stat_word;
    always_comb begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[CTRL_RUN0]   = run_r[0];
        ctrl_word[CTRL_RUN1]   = run_r[1];
        ctrl_word[CTRL_COMPAT] = compat_r;
        ctrl_word[CTRL_APPLY0] = apply_r[0];
        ctrl_word[CTRL_APPLY1] = apply_r[1];
        ctrl_word[CTRL_TPS_LSB +: TPS_W] = tps_r;
        stat_word = 32'h0000_0000;
        stat_word[1:0] = pwm_r;
        stat_word[STAT_OCR0_LSB +: 8] = ocr_r[0];
        stat_word[STAT_OCR1_LSB +: 8] = ocr_r[1];
    end

    // read data sampled at the address phase: a read right after a write sees the old value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wph_r    <= 1'b0;
            wadr_r   <= '0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            wph_r  <= addr_ok && hwrite;
            wadr_r <= haddr[DTP_AW-1:0];
            hrdata_r <= (addr_ok && !hwrite) ?
                rd_word(haddr[DTP_AW-1:0], mode_r, conb_r, ctrl_word, tf_r, {high_r[0], low_r[0]},
                        {high_r[1], low_r[1]}, {rh_r[0], rl_r[0]}, {rh_r[1], rl_r[1]}, stat_word) : 32'h0000_0000;
        end
    end

    logic [1:0] cw;
    assign cw[0] = wr_hit(wph_r, wadr_r, OFS_CNT0);
    assign cw[1] = wr_hit(wph_r, wadr_r, OFS_CNT1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_r   <= MODE_RST;
            conb_r   <= CONB_RST;
            run_r    <= 2'b00;
            compat_r <= 1'b0;
            apply_r  <= 2'b00;
            tps_r    <= '0;
        end else begin
            if (wr_hit(wph_r, wadr_r, OFS_MODE)) mode_r <= hwdata[7:0];
            if (wr_hit(wph_r, wadr_r, OFS_CONB)) conb_r <= hwdata[7:0];
            if (wr_hit(wph_r, wadr_r, OFS_CTRL)) begin
                run_r    <= {hwdata[CTRL_RUN1], hwdata[CTRL_RUN0]};
                compat_r <= hwdata[CTRL_COMPAT];
                apply_r  <= {hwdata[CTRL_APPLY1], hwdata[CTRL_APPLY0]};
                tps_r    <= hwdata[CTRL_TPS_LSB +: TPS_W];
            end
        end
    end

    // reload registers only ever written by software; mode 2 leaves them as scratch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rl_r <= '{RLD_RST, RLD_RST};
            rh_r <= '{RLD_RST, RLD_RST};
        end else begin
            if (wr_hit(wph_r, wadr_r, OFS_RLD0)) begin
                rl_r[0] <= hwdata[7:0];
                rh_r[0] <= hwdata[15:8];
            end
            if (wr_hit(wph_r, wadr_r, OFS_RLD1)) begin
                rl_r[1] <= hwdata[7:0];
                rh_r[1] <= hwdata[15:8];
            end
        end
    end

    // ---------------- pin synchronisers ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gs1_r <= 2'b00;
            gs2_r <= 2'b00;
            ps1_r <= 2'b11;
            ps2_r <= 2'b11;
            ps3_r <= 2'b11;
        end else begin
            gs1_r <= {ext_gate_input_one, ext_gate_input_zero};
            gs2_r <= gs1_r;
            ps1_r <= {timer_pin_b_in, timer_pin_a_in};
            ps2_r <= ps1_r;
            ps3_r <= ps2_r;
        end
    end

    // ---------------- shared prescaler ----------------
    logic       tps_tick;
    logic [1:0] tick;
    assign tps_tick = (pcnt_r == tps_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pcnt_r <= '0;
            half_r <= 2'b00;
        end else begin
            pcnt_r <= tps_tick ? '0 : pcnt_r + 1'b1;
            if (tps_tick) half_r <= ~half_r;
        end
    end

    // fast mode: prescale only with apply bit; compat: always, apply bit halves again
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            tick[n] = !(compat_r || apply_r[n]) ||
                      (tps_tick && (!(compat_r && apply_r[n]) || half_r[n]));
        end
    end

    // ---------------- counters ----------------
    dtp_mode_e  md [2];
    logic [1:0] pen, ct, gate, go, lov, hov, hstep, lstep, ov;
    logic [7:0] lo_nxt [2];
    logic [7:0] hi_nxt [2];
    logic       split0;
    logic [15:0] wide;

    assign split0 = (md[0] == DTP_M_SPLIT);

    always_comb begin
        wide = 16'h0000;
        for (int n = 0; n < 2; n++) begin
            md[n]   = dtp_mode_e'(mode_r[n*MODE_T1_SHIFT + MODE_M_LSB +: 2]);
            ct[n]   = mode_r[n*MODE_T1_SHIFT + MODE_CT];
            gate[n] = mode_r[n*MODE_T1_SHIFT + MODE_GATE];
            pen[n]  = conb_r[n == 0 ? CONB_PEN0 : CONB_PEN1];
            // counter select ignored in PWM (the pin is then an output)
            go[n] = run_r[n] && (!gate[n] || gs2_r[n]) &&
                    ((ct[n] && !pen[n]) ? (ps3_r[n] && !ps2_r[n]) : tick[n]);
            lo_nxt[n] = low_r[n];
            hi_nxt[n] = high_r[n];
            lov[n] = 1'b0;
            hov[n] = 1'b0;
            hstep[n] = 1'b0;
            lstep[n] = 1'b0;
            case (md[n])
                DTP_M_VAR: begin
                    if (go[n]) begin
                        if ((low_r[n] & psc_mask(conb_r[n == 0 ? CONB_PSC0_LSB : CONB_PSC1_LSB +: 3]))
                            == psc_mask(conb_r[n == 0 ? CONB_PSC0_LSB : CONB_PSC1_LSB +: 3])) begin
                            lo_nxt[n] = 8'h00;
                            hi_nxt[n] = high_r[n] + 8'h01;
                            hstep[n]  = 1'b1;
                            hov[n]    = (high_r[n] == BYTE_MAX);
                        end else begin
                            lo_nxt[n] = low_r[n] + 8'h01;
                        end
                    end
                    ov[n] = hov[n];
                end
                DTP_M_WIDE: begin
                    if (go[n] && pen[n]) begin
                        if (low_r[n] == BYTE_MAX) begin
                            lo_nxt[n] = rl_r[n];
                            hi_nxt[n] = high_r[n] + 8'h01;
                            hstep[n]  = 1'b1;
                            hov[n]    = (high_r[n] == BYTE_MAX);
                        end else begin
                            lo_nxt[n] = low_r[n] + 8'h01;
                        end
                    end else if (go[n]) begin
                        if ({high_r[n], low_r[n]} == 16'hFFFF) begin
                            lo_nxt[n] = rl_r[n];
                            hi_nxt[n] = rh_r[n];
                            hov[n]    = 1'b1;
                        end else begin
                            wide = {high_r[n], low_r[n]} + 16'h0001;
                            lo_nxt[n] = wide[7:0];
                            hi_nxt[n] = wide[15:8];
                        end
                    end
                    ov[n] = hov[n];
                end
                DTP_M_RELOAD: begin
                    if (go[n]) begin
                        lov[n]    = (low_r[n] == BYTE_MAX);
                        lo_nxt[n] = lov[n] ? high_r[n] : low_r[n] + 8'h01;
                    end
                    ov[n] = lov[n];
                end
                default: begin
                    // timer 1 holds in its own split mode
                    if (n == 0) begin
                        lstep[n] = go[n];
                        if (go[n]) begin
                            lov[n]    = (low_r[n] == BYTE_MAX);
                            lo_nxt[n] = low_r[n] + 8'h01;
                        end
                        if (run_r[1] && tick[0]) begin
                            hstep[n]  = 1'b1;
                            hov[n]    = (high_r[n] == BYTE_MAX);
                            hi_nxt[n] = high_r[n] + 8'h01;
                        end
                    end
                    ov[n] = lov[n];
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_r  <= '{CNT_RST, CNT_RST};
            high_r <= '{CNT_RST, CNT_RST};
        end else begin
            for (int n = 0; n < 2; n++) begin
                if (cw[n]) begin
                    low_r[n]  <= hwdata[7:0];
                    high_r[n] <= hwdata[15:8];
                end else begin
                    low_r[n]  <= lo_nxt[n];
                    high_r[n] <= hi_nxt[n];
                end
            end
        end
    end

    // flags: hardware set wins over software write-one-to-clear
    logic [1:0] tf_set;
    assign tf_set[0] = ov[0];
    assign tf_set[1] = split0 ? hov[0] : ov[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tf_r   <= 2'b00;
            baud_r <= 1'b0;
        end else begin
            tf_r   <= (wr_hit(wph_r, wadr_r, OFS_FLAGS) ? (tf_r & ~hwdata[1:0]) : tf_r) | tf_set;
            baud_r <= ov[1];
        end
    end

    // ---------------- PWM channels ----------------
    logic [1:0] ch_step, ch_wrap, ch_tog, ch_pwm;
    logic [7:0] ch_val  [2];
    logic [7:0] ch_duty [2];

    always_comb begin
        if (split0) begin
            ch_step = {hstep[0], lstep[0]};
            ch_wrap = {hov[0], lov[0]};
            ch_val  = '{lo_nxt[0], hi_nxt[0]};
            ch_duty = '{rl_r[0], rh_r[0]};
            ch_pwm  = 2'b11;
            ch_tog  = 2'b00;
        end else begin
            ch_step = hstep;
            ch_wrap = hov;
            ch_val  = '{hi_nxt[0], hi_nxt[1]};
            ch_duty = '{rh_r[0], rh_r[1]};
            for (int c = 0; c < 2; c++) begin
                ch_pwm[c] = (md[c] == DTP_M_VAR) || (md[c] == DTP_M_WIDE);
                ch_tog[c] = (md[c] == DTP_M_RELOAD) && lov[c];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_r <= 2'b00;
            ocr_r <= '{RLD_RST, RLD_RST};
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (!pen[c]) begin
                    pwm_r[c] <= 1'b0;
                end else if (ch_tog[c]) begin
                    pwm_r[c] <= ~pwm_r[c];
                end else if (ch_pwm[c] && ch_step[c]) begin
                    if (ch_wrap[c]) begin
                        ocr_r[c] <= ch_duty[c];
                        pwm_r[c] <= (ch_duty[c] != 8'h00);
                    end else if (ch_val[c] == ocr_r[c]) begin
                        pwm_r[c] <= 1'b0;
                    end
                end
            end
        end
    end

    assign timer_pin_a_out  = pwm_r[0];
    assign timer_pin_b_out  = pwm_r[1];
    assign timer_pin_a_oe_n = ~pen[0];
    assign timer_pin_b_oe_n = ~pen[1];
    assign baud_tick        = baud_r;

    // ---------------- checks ----------------
    default clocking cb_main @(posedge hclk); endclocking
    default disable iff (!hresetn);

    reload_keep_a: assert property ((md[0] == DTP_M_RELOAD && lov[0] && !cw[0]) |=>
        (low_r[0] == $past(high_r[0]) && high_r[0] == $past(high_r[0]) && tf_r[0]))
        else $error("mode 2 reload or flag wrong");
    fast_bypass_a: assert property ((!compat_r && !apply_r[0] && run_r[0] && !gate[0] && !ct[0] && !cw[0] &&
        md[0] == DTP_M_RELOAD && low_r[0] != BYTE_MAX) |=> low_r[0] == $past(low_r[0]) + 8'h01)
        else $error("prescale applied without apply bit");
    compat_gap_a: assert property ((compat_r && tps_tick && tps_r != '0 &&
        !wr_hit(wph_r, wadr_r, OFS_CTRL)) |=> !tick[0])
        else $error("compat prescale not applied");
    t1_hold_a: assert property ((md[1] == DTP_M_SPLIT && !cw[1]) |=>
        ($stable(low_r[1]) && $stable(high_r[1])))
        else $error("timer 1 moved in mode 3");
    split_high_a: assert property ((split0 && !run_r[1] && !cw[0]) |=> $stable(high_r[0]))
        else $error("split high ran without run one");
    split_flag_a: assert property ((split0 && !hov[0] && !tf_r[1] &&
        !wr_hit(wph_r, wadr_r, OFS_FLAGS)) |=> !tf_r[1])
        else $error("timer 1 flagged during split");
    gate_hold_a: assert property ((gate[0] && !gs2_r[0] && !cw[0] && md[0] != DTP_M_WIDE) |=>
        $stable(low_r[0]))
        else $error("gate did not stop count");
    duty_zero_a: assert property ((pen[0] && ch_pwm[0] && ch_step[0] && ch_wrap[0] &&
        ch_duty[0] == 8'h00) |=> !pwm_r[0] [*2])
        else $error("zero duty drove high");
    ocr_latch_a: assert property ($changed(ocr_r[1]) |-> $past(ch_wrap[1] && ch_step[1]))
        else $error("compare loaded off wrap");
    toggle_a: assert property ((pen[0] && ch_tog[0]) |=> pwm_r[0] != $past(pwm_r[0]))
        else $error("mode 2 did not toggle");
endmodule // dtp_timer
`default_nettype wire

//--- verification/dtp_pins_model.sv
// Purpose: far side of the timer pins and gate inputs
// Assumes: released timer pins sit at their pull-up level
// Notes:   gate level is commanded by the bench
`timescale 1ns/100ps
`default_nettype none
module dtp_pins_model (
    input  wire logic gate_lvl,
    input  wire logic a_out,
    input  wire logic a_oe_n,
    input  wire logic b_out,
    input  wire logic b_oe_n,
    output logic      external_hold_select_zero,
    output logic      external_hold_select_one,
    output logic      pin_a,
    output logic      pin_b
);
    assign external_hold_select_zero = gate_lvl;
    assign external_hold_select_one = gate_lvl;
    // undriven pin floats high, not to its last value
    assign pin_a = a_oe_n ? 1'b1 : a_out;
    assign pin_b = b_oe_n ? 1'b1 : b_out;
endmodule // dtp_pins_model
`default_nettype wire

//--- verification/dual_timer_pwm_modes_tb.sv
// Purpose: register-level bench for the dual timer / PWM block
// Assumes: zero-wait slave, pin waveforms timed in clock cycles
// Notes:   counter select stays 0 throughout
`timescale 1ns/100ps
`default_nettype none
module dual_timer_pwm_modes_tb;
    import dtp_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, gate_lvl, rdy, hresp;
    logic        a_out, a_oe_n, b_out, b_oe_n, g0, g1, pin_a, pin_b, baud;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q, sv;
    logic [31:0] ctl [3] = '{32'h1, 32'h109, 32'h10D};
    int          err_total, n_compared, cyc, hi, per, n_baud;

    dtp_timer dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(rdy), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(rdy), .hresp(hresp), .ext_gate_input_zero(g0), .ext_gate_input_one(g1),
        .timer_pin_a_in(pin_a), .timer_pin_a_out(a_out), .timer_pin_a_oe_n(a_oe_n),
        .timer_pin_b_in(pin_b), .timer_pin_b_out(b_out), .timer_pin_b_oe_n(b_oe_n), .baud_tick(baud));
    dtp_pins_model pins (.gate_lvl(gate_lvl), .a_out(a_out), .a_oe_n(a_oe_n), .b_out(b_out),
        .b_oe_n(b_oe_n), .external_hold_select_zero(g0), .external_hold_select_one(g1), .pin_a(pin_a), .pin_b(pin_b));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (baud === 1'b1) n_baud++;
        if (cyc == 40000) begin
            err_total++;
            close_out;
        end
    end

    task chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // address phase held until ready, then data phase until ready
    task xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {26'h0, a};
        do @(posedge hclk); while (rdy !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (rdy !== 1'b1);
        q = hrdata;
    endtask

    task wr(input logic [5:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task rd(input logic [5:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    function automatic logic pv(input logic s);
        return s ? pin_b : pin_a;
    endfunction

    // high time and period of one full cycle from a rising edge; 0 if stuck
    task meas(input logic s);
        int n;
        hi = 0;
        n = 0;
        while (pv(s) !== 1'b0 && n < 3000) begin @(posedge hclk); n++; end
        while (pv(s) !== 1'b1 && n < 3000) begin @(posedge hclk); n++; end
        while (pv(s) === 1'b1 && n < 3000) begin @(posedge hclk); n++; hi++; end
        per = hi;
        while (pv(s) === 1'b0 && n < 3000) begin @(posedge hclk); n++; per++; end
    endtask

    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {err_total, n_compared, cyc, n_baud} = '0;
        gate_lvl = 1'b1;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        chk(a_oe_n, 1);
        rd(OFS_CONB, 32'h24);
        rd(OFS_MODE, 32'h0);
        $display("test reset done");
        wr(OFS_MODE, 32'h2);
        wr(OFS_CNT0, 32'hF0F0);
        wr(OFS_CONB, 32'h64);
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL, ctl[i]);
            meas(1'b0);
            chk(hi, 16 << i);
            chk(per, 32 << i);
        end
        chk(a_oe_n, 0);
        xfer(1'b0, OFS_CNT0, 32'h0);
        chk(q[15:8], 8'hF0);
        rd(OFS_FLAGS, 32'h1);
        wr(OFS_RLD1, 32'hA55A);
        rd(OFS_RLD1, 32'hA55A);
        wr(OFS_MODE, 32'hA);
        gate_lvl <= 1'b0;
        repeat (6) @(posedge hclk);
        xfer(1'b0, OFS_CNT0, 32'h0);
        sv = q;
        repeat (40) @(posedge hclk);
        rd(OFS_CNT0, sv);
        gate_lvl <= 1'b1;
        wr(OFS_CTRL, 32'h1);
        meas(1'b0);
        chk(per, 32);
        $display("test frequency done");
        wr(OFS_CONB, 32'h60);
        wr(OFS_MODE, 32'h0);
        wr(OFS_RLD0, 32'h40FE);
        meas(1'b0);
        chk(hi, 128);
        chk(per, 512);
        wr(OFS_MODE, 32'h1);
        wr(OFS_RLD0, 32'h80FE);
        meas(1'b0);
        chk(hi, 256);
        chk(per, 512);
        wr(OFS_RLD0, 32'h00FE);
        meas(1'b0);
        chk(hi, 0);
        $display("test duty done");
        wr(OFS_CNT1, 32'h1234);
        wr(OFS_MODE, 32'h33);
        wr(OFS_CONB, 32'hE4);
        wr(OFS_RLD0, 32'h4020);
        wr(OFS_FLAGS, 32'h3);
        wr(OFS_CTRL, 32'h3);
        meas(1'b0);
        chk(hi, 32);
        chk(per, 256);
        meas(1'b1);
        chk(hi, 64);
        chk(per, 256);
        rd(OFS_CNT1, 32'h1234);
        rd(OFS_FLAGS, 32'h3);
        chk(b_oe_n, 0);
        xfer(1'b0, OFS_STAT, 32'h0);
        chk(q[23:8], 16'h4020);
        // timer 1 in reload mode beside the split: baud pulses every 16 cycles
        wr(OFS_RLD1, 32'h5AA5);
        wr(OFS_CNT1, 32'hF0F0);
        wr(OFS_MODE, 32'h23);
        n_baud = 0;
        repeat (168) @(posedge hclk);
        chk(n_baud, 10);
        rd(OFS_RLD1, 32'h5AA5);
        $display("test split done");
        close_out;
    end
endmodule // dual_timer_pwm_modes_tb
`default_nettype wire
